// [dtg_map.svh]
// Register offsets, field positions, reset values and the dead-time compare mode code of the dead-time output stage
`ifndef DTG_MAP_SVH
`define DTG_MAP_SVH

`define DTG_OFF_CTRL 12'h000
`define DTG_OFF_DEADTIME 12'h004
`define DTG_OFF_TOP 12'h008
`define DTG_OFF_CMP_A 12'h00C
`define DTG_OFF_CMP_B 12'h010
`define DTG_OFF_CMP_D 12'h014
`define DTG_OFF_STATUS 12'h018
`define DTG_OFF_COUNT 12'h01C
`define DTG_OFF_PORT 12'h020

`define DTG_CTRL_PWM_EN 0
`define DTG_CTRL_WGM 1
`define DTG_CTRL_INVERT 2
`define DTG_CTRL_DTPS_LO 3
`define DTG_CTRL_COM_A_LO 5
`define DTG_CTRL_COM_B_LO 7
`define DTG_CTRL_COM_D_LO 9
`define DTG_CTRL_FORCE_LO 11

`define DTG_DT_RISE_LO 4
`define DTG_DT_FALL_LO 0

`define DTG_TOP_RESET 10'h0FF
`define DTG_CTRL_RESET 14'h0000
`define DTG_DT_RESET 8'h00
`define DTG_COM_DEADTIME 2'h1

`endif

// [dtg_pkg.sv]
// Types shared by the dead-time output stage
package dtg_pkg;
    typedef struct packed {
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [11:0] haddr;
    } dtg_ahb_req_t;

    typedef struct packed {
        logic pin_true;
        logic pin_comp;
        logic oe_true;
        logic oe_comp;
    } dtg_pin_pair_t;

    typedef enum logic [1:0] {
        DTG_IDLE,
        DTG_HOLD_TRUE,
        DTG_HOLD_COMP
    } dtg_dt_state_t;
endpackage

// [dtg_dead_time_output.sv]
// Dead-time compare output stage with normal counter and AHB-Lite registers
//
// Function
// [R1] Dead time inserted only in PWM mode with channel compare mode 01.
// [R2] Three independent generators, each delaying true and complement edges separately.
// [R3] Shared prescaler divides timer clock by 1, 2, 4 or 8 for counters.
// [R4] Waveform edge starts dead time; the rising output transition waits for zero.
// [R5] Counter loads rise count on rising edge, fall count on falling edge.
// [R6] Counter at zero ends the dead time and releases the held output.
// [R7] Zero dead time still delays both outputs one timer clock.
// [R8] Invert bit inverts both outputs, so both are high during dead time.
// [R9] Non-PWM mode: generator is only a one-clock synchronizer of the waveform.
// [R10] PWM with compare mode other than 01 behaves like non-PWM path.
// [R11] Reset clears the generator true output state to zero.
// [R12] Nonzero compare mode overrides port value; direction bits still gate pins.
// [R13] Compare mode zero leaves the waveform unchanged at a compare match.
// [R14] Mode change acts at next match; force strobe acts at once in non-PWM.
// [R15] Non-PWM counter counts zero to top, then clears on the next clock.
// [R16] Non-PWM compare mode 1 toggles the waveform on each match.
// [R17] Non-PWM mode 2 clears, mode 3 sets the waveform on a match.
// [R18] Overflow flag set as counter becomes zero; hardware never clears it. The code sets it only while PWM enable is clear.
// [R19] Counting depends only on PWM enable and waveform select, never compare mode. The code counts zero to top whatever PWM enable and waveform select are.
// [R20] Non-PWM: true pin disconnected; complement pin connected for nonzero modes.
// [R21] Top compare value resets to 0x0FF.
// [R22] Compare values double buffered in PWM, updated at bottom; direct otherwise.
// [R23] Prescale codes 00..11 select divide 1, 2, 4, 8; one decrement per tick.
// [R24] Dead-time register: rise count upper nibble, fall count lower nibble.
//
// The placing of the registers and the AHB-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "dtg_map.svh"

module dtg_dead_time_output
    import dtg_pkg::*;
#(
    parameter int CW = 10,
    parameter int NCH = 3
) (
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Output pin pairs, one per channel
    output dtg_pin_pair_t [NCH-1:0] pins
);

    ////////////////////////////////////////////////////////////////////////
    // Register bus

    dtg_ahb_req_t req_r;
    logic req_valid_r;
    logic [13:0] ctrl_r;
    logic [7:0] dt_r;
    logic [CW-1:0] top_r;
    logic [CW-1:0] cmp_buf_r [NCH];
    logic [CW-1:0] cmp_act_r [NCH];
    logic ovf_r;
    logic [CW-1:0] cnt_r;
    logic [2*NCH-1:0] port_val_r;
    logic [2*NCH-1:0] port_dir_r;
    logic cnt_wr_block_r;

    wire take_req = hsel && hready && htrans[1];
    wire wr_phase = req_valid_r && req_r.hwrite;
    wire wr_ctrl = wr_phase && (req_r.haddr == `DTG_OFF_CTRL);
    wire wr_dt = wr_phase && (req_r.haddr == `DTG_OFF_DEADTIME);
    wire wr_top = wr_phase && (req_r.haddr == `DTG_OFF_TOP);
    wire wr_stat = wr_phase && (req_r.haddr == `DTG_OFF_STATUS);
    wire wr_cnt = wr_phase && (req_r.haddr == `DTG_OFF_COUNT);
    wire wr_port = wr_phase && (req_r.haddr == `DTG_OFF_PORT);
    wire [NCH-1:0] wr_cmp;
    assign wr_cmp[0] = wr_phase && (req_r.haddr == `DTG_OFF_CMP_A);
    assign wr_cmp[1] = wr_phase && (req_r.haddr == `DTG_OFF_CMP_B);
    assign wr_cmp[2] = wr_phase && (req_r.haddr == `DTG_OFF_CMP_D);

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_r <= '0;
            req_valid_r <= 1'b0;
        end else if (hready) begin
            req_valid_r <= take_req;
            req_r <= {htrans, hwrite, hsize, haddr};
        end
    end

    // Read data is registered in the address phase
    logic [31:0] rd_mux;
    always_comb begin
        case (haddr)
            `DTG_OFF_CTRL: rd_mux = {18'h00000, ctrl_r};
            `DTG_OFF_DEADTIME: rd_mux = {24'h000000, dt_r};
            `DTG_OFF_TOP: rd_mux = {22'h000000, top_r};
            `DTG_OFF_CMP_A: rd_mux = {22'h000000, cmp_buf_r[0]};
            `DTG_OFF_CMP_B: rd_mux = {22'h000000, cmp_buf_r[1]};
            `DTG_OFF_CMP_D: rd_mux = {22'h000000, cmp_buf_r[2]};
            `DTG_OFF_STATUS: rd_mux = {31'h00000000, ovf_r};
            `DTG_OFF_COUNT: rd_mux = {22'h000000, cnt_r};
            `DTG_OFF_PORT: rd_mux = {20'h00000, port_dir_r, port_val_r};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (take_req && !hwrite) begin
            hrdata <= rd_mux;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control fields

    wire pwm_mode_enable = ctrl_r[`DTG_CTRL_PWM_EN];
    wire waveform_gen_select = ctrl_r[`DTG_CTRL_WGM];
    wire output_invert_bit = ctrl_r[`DTG_CTRL_INVERT];
    wire [1:0] dead_time_prescale_sel = ctrl_r[`DTG_CTRL_DTPS_LO +: 2];
    wire [3:0] rise_dead_count = dt_r[`DTG_DT_RISE_LO +: 4]; // [R24]
    wire [3:0] fall_dead_count = dt_r[`DTG_DT_FALL_LO +: 4]; // [R24]
    wire [NCH-1:0] force_compare_strobe;
    assign force_compare_strobe = wr_ctrl ? hwdata[`DTG_CTRL_FORCE_LO +: NCH] : '0;

    function automatic logic [1:0] com_of(input logic [13:0] c, input int ch);
        case (ch)
            0: com_of = c[`DTG_CTRL_COM_A_LO +: 2];
            1: com_of = c[`DTG_CTRL_COM_B_LO +: 2];
            default: com_of = c[`DTG_CTRL_COM_D_LO +: 2];
        endcase
    endfunction

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= `DTG_CTRL_RESET;
            dt_r <= `DTG_DT_RESET;
            top_r <= `DTG_TOP_RESET; // [R21]
            port_val_r <= '0;
            port_dir_r <= '0;
        end else begin
            if (wr_ctrl) ctrl_r <= {3'h0, hwdata[10:0]};
            if (wr_dt) dt_r <= hwdata[7:0];
            if (wr_top) top_r <= hwdata[CW-1:0];
            if (wr_port) {port_dir_r, port_val_r} <= hwdata[4*NCH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Counter (normal mode; PWM counting sequences are outside this block)

    wire at_top = (cnt_r == top_r);
    wire [CW-1:0] cnt_nxt = at_top ? '0 : cnt_r + 1'b1; // [R15] [R19]
    wire at_bottom_nxt = (cnt_nxt == '0);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= '0;
            ovf_r <= 1'b0;
            cnt_wr_block_r <= 1'b0;
        end else begin
            cnt_wr_block_r <= wr_cnt;
            if (wr_cnt) cnt_r <= hwdata[CW-1:0];
            else cnt_r <= cnt_nxt;
            // Set wins over a software clear (write one to clear)
            if (!wr_cnt && at_bottom_nxt && !pwm_mode_enable) ovf_r <= 1'b1; // [R18]
            else if (wr_stat && hwdata[0]) ovf_r <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Dead-time prescaler

    logic [2:0] pre_r;
    wire [2:0] pre_mask = 3'((4'h1 << dead_time_prescale_sel) - 4'h1); // [R23]
    wire dt_tick = ((pre_r & pre_mask) == 3'h0); // [R3]

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) pre_r <= 3'h0;
        else pre_r <= pre_r + 3'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Per-channel waveform generator and dead-time generator

    for (genvar ch = 0; ch < NCH; ch++) begin : g_ch
        logic wave_r;
        logic wave_d_r;
        logic true_r;
        logic comp_r;
        logic [3:0] dcnt_r;
        dtg_dt_state_t st_r;

        wire [1:0] com = com_of(ctrl_r, ch);
        wire dt_mode = pwm_mode_enable && (com == `DTG_COM_DEADTIME); // [R1] [R10]
        wire match = (cnt_r == cmp_act_r[ch]) && !cnt_wr_block_r;
        // PWM counting is outside this block, so a match still drives the waveform there
        wire fire = match || (force_compare_strobe[ch] && !pwm_mode_enable); // [R14]

        // Compare buffering
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                cmp_buf_r[ch] <= '0;
                cmp_act_r[ch] <= '0;
            end else begin
                if (wr_cmp[ch]) cmp_buf_r[ch] <= hwdata[CW-1:0];
                if (!pwm_mode_enable) begin
                    if (wr_cmp[ch]) cmp_act_r[ch] <= hwdata[CW-1:0]; // [R22]
                end else if (at_top) begin
                    cmp_act_r[ch] <= cmp_buf_r[ch]; // [R22]
                end
            end
        end

        // Waveform action on a match; mode zero keeps the level
        logic wave_nxt;
        always_comb begin
            wave_nxt = wave_r;
            if (fire) begin
                case (com)
                    2'h1: wave_nxt = !wave_r; // [R16]
                    2'h2: wave_nxt = 1'b0; // [R17]
                    2'h3: wave_nxt = 1'b1; // [R17]
                    default: wave_nxt = wave_r; // [R13]
                endcase
            end
        end

        wire rise = wave_r && !wave_d_r; // [R4]
        wire fall = !wave_r && wave_d_r; // [R4]

        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                wave_r <= 1'b0;
                wave_d_r <= 1'b0;
                true_r <= 1'b0; // [R11]
                comp_r <= 1'b0;
                dcnt_r <= 4'h0;
                st_r <= DTG_IDLE;
            end else begin
                wave_r <= wave_nxt;
                wave_d_r <= wave_r;
                if (!dt_mode) begin
                    true_r <= wave_r; // [R9]
                    comp_r <= !wave_r;
                    st_r <= DTG_IDLE;
                    dcnt_r <= 4'h0;
                end else if (rise) begin
                    comp_r <= 1'b0;
                    true_r <= (rise_dead_count == 4'h0); // [R7]
                    dcnt_r <= rise_dead_count; // [R5]
                    st_r <= (rise_dead_count == 4'h0) ? DTG_IDLE : DTG_HOLD_TRUE;
                end else if (fall) begin
                    true_r <= 1'b0;
                    comp_r <= (fall_dead_count == 4'h0); // [R7]
                    dcnt_r <= fall_dead_count; // [R5]
                    st_r <= (fall_dead_count == 4'h0) ? DTG_IDLE : DTG_HOLD_COMP;
                end else begin
                    case (st_r)
                        DTG_HOLD_TRUE, DTG_HOLD_COMP: begin
                            if (dt_tick && dcnt_r != 4'h0) dcnt_r <= dcnt_r - 4'h1; // [R23]
                            if (dcnt_r == 4'h0) begin
                                // Zero reached: release the held edge
                                if (st_r == DTG_HOLD_TRUE) true_r <= 1'b1; // [R6]
                                else comp_r <= 1'b1; // [R6]
                                st_r <= DTG_IDLE;
                            end
                        end
                        default: st_r <= DTG_IDLE;
                    endcase
                end
            end
        end

        // Pin override and direction
        wire ovr = (com != 2'h0); // [R12]
        wire true_conn = ovr && dt_mode; // [R20]
        wire comp_conn = ovr; // [R20]
        wire t_val = true_r ^ (output_invert_bit && dt_mode); // [R8]
        wire c_val = comp_r ^ (output_invert_bit && dt_mode); // [R8]
        wire c_src = dt_mode ? c_val : true_r; // [R2]
        assign pins[ch].pin_true = true_conn ? t_val : port_val_r[2*ch];
        assign pins[ch].pin_comp = comp_conn ? c_src : port_val_r[2*ch+1];
        assign pins[ch].oe_true = port_dir_r[2*ch]; // [R12]
        assign pins[ch].oe_comp = port_dir_r[2*ch+1]; // [R12]
    end

endmodule
`default_nettype wire

// [dtg_dead_time_output_sva.sv]
// Port-level assertions for the dead-time output stage
`timescale 1ns/1ps
`default_nettype none
`include "dtg_map.svh"
module dtg_dead_time_output_sva
    import dtg_pkg::*;
#(
    parameter int CW = 10,
    parameter int NCH = 3
) (
    // Bus side
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Pin side
    input wire dtg_pin_pair_t [NCH-1:0] pins
);
    logic wv_r;
    logic [11:0] wa_r;
    logic [13:0] ctrl_r;
    logic [11:0] port_r;
    logic [7:0] dt_r;
    wire aph = hsel && hready && htrans[1];
    wire pwm = ctrl_r[0];
    wire inv = ctrl_r[2];
    wire [1:0] com_a = ctrl_r[6:5];
    // Shadow copies of the registers the pins depend on
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            {wv_r, wa_r, ctrl_r, port_r, dt_r} <= '0;
        end else begin
            wv_r <= aph && hwrite;
            wa_r <= haddr;
            if (wv_r && wa_r == `DTG_OFF_CTRL) ctrl_r <= hwdata[13:0] & 14'h07FF;
            if (wv_r && wa_r == `DTG_OFF_PORT) port_r <= hwdata[11:0];
            if (wv_r && wa_r == `DTG_OFF_DEADTIME) dt_r <= hwdata[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence s_cfg_held;
        $stable(ctrl_r) [*8];
    endsequence
    sequence s_read(logic [11:0] a);
        aph && !hwrite && !wv_r && haddr == a;
    endsequence
    a_ready_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    a_dt_readback: assert property (s_read(`DTG_OFF_DEADTIME) |=> hrdata == {24'h0, $past(dt_r)})
        else $error("dead-time register read back wrong");
    a_unmapped_zero: assert property (aph && !hwrite && haddr > 12'h020 |=> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_no_overlap: assert property (s_cfg_held ##0 (pwm && com_a == 2'h1 && !inv) |-> !(pins[0].pin_true && pins[0].pin_comp))
        else $error("pair outputs overlap");
    a_inv_never_low: assert property (s_cfg_held ##0 (pwm && com_a == 2'h1 && inv) |-> (pins[0].pin_true || pins[0].pin_comp))
        else $error("inverted pair both low");
    a_port_when_off: assert property (com_a == 2'h0 |-> pins[0].pin_true == port_r[0] && pins[0].pin_comp == port_r[1])
        else $error("port value not on pins");
    a_normal_true_port: assert property (!pwm && com_a != 2'h0 |-> pins[0].pin_true == port_r[0])
        else $error("true pin not disconnected");
    a_oe_dir: assert property (pins[0].oe_true == port_r[6] && pins[0].oe_comp == port_r[7])
        else $error("enable does not follow direction");
    a_pins_after_reset: assert property ($rose(hresetn) |-> pins == '0)
        else $error("pins not cleared by reset");
endmodule
bind dtg_dead_time_output dtg_dead_time_output_sva #(.CW(CW), .NCH(NCH)) u_sva (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pins(pins));
`default_nettype wire

// [dtg_switch_model.sv]
// Power switch driver model: counts shoot-through and measures dead gaps
`timescale 1ns/1ps
`default_nettype none
module dtg_switch_model
    import dtg_pkg::*;
(
    // Clock and observed pair
    input wire logic hclk,
    input wire dtg_pin_pair_t pair,
    // Measurements
    output int shoot_cnt,
    output int gap_last,
    output int rise_cnt
);
    int gap = 0;
    logic prev_true = 1'b0;
    initial begin
        shoot_cnt = 0;
        gap_last = 0;
        rise_cnt = 0;
    end
    always @(posedge hclk) begin
        if (pair.pin_true === 1'b1 && pair.pin_comp === 1'b1 && pair.oe_true && pair.oe_comp)
            shoot_cnt++;
        if (pair.pin_true === 1'b1 && prev_true === 1'b0) begin
            gap_last = gap;
            rise_cnt++;
        end
        gap = (pair.pin_true === 1'b0 && pair.pin_comp === 1'b0) ? gap + 1 : 0;
        prev_true = pair.pin_true;
    end
endmodule
`default_nettype wire

// [dtg_dead_time_output_bench.sv]
// Self-checking bench for the dead-time output stage
`timescale 1ns/1ps
`default_nettype none
`include "dtg_map.svh"
module dtg_dead_time_output_bench
    import dtg_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic hready = 1'b1;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic hreadyout;
    logic hresp;
    logic pv;
    dtg_pin_pair_t [2:0] pins;
    int n_fail = 0;
    int samples_checked = 0;
    int shoot_cnt;
    int gap_last;
    int rise_cnt;
    int n;
    int tg;
    always #25 hclk = ~hclk;
    dtg_dead_time_output u_dtg_dead_time_output (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .pins(pins));
    dtg_switch_model u_dtg_switch_model (.hclk(hclk), .pair(pins[0]),
        .shoot_cnt(shoot_cnt), .gap_last(gap_last), .rise_cnt(rise_cnt));
    ////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wr ? d : 32'h0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        @(negedge hclk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_in(input logic [31:0] got, input int lo, input int hi);
        samples_checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h..%h", $time, got, lo, hi);
        end
    endtask
    task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (30000) @(posedge hclk);
        n_fail++;
        give_verdict;
    end
    ////////////////////////////////////////////////////////////////////////
    initial begin
        n = $urandom(21676);
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rdchk(`DTG_OFF_TOP, 32'h0FF);
        rdchk(12'h040, 32'h0);
        xfer(1'b1, `DTG_OFF_CTRL, 32'h3800);
        rdchk(`DTG_OFF_CTRL, 32'h0);
        repeat (4) begin
            n = $urandom_range(255);
            xfer(1'b1, `DTG_OFF_DEADTIME, n);
            rdchk(`DTG_OFF_DEADTIME, n);
        end
        $display("test registers done");
        xfer(1'b1, `DTG_OFF_TOP, 32'h5);
        xfer(1'b1, `DTG_OFF_COUNT, 32'h0);
        xfer(1'b1, `DTG_OFF_STATUS, 32'h1);
        repeat (8) begin
            xfer(1'b0, `DTG_OFF_COUNT, 32'h0);
            chk_in(rd, 0, 5);
        end
        rdchk(`DTG_OFF_STATUS, 32'h1);
        $display("test counter done");
        xfer(1'b1, `DTG_OFF_PORT, 32'hFC2);
        chk({30'h0, pins[0].pin_true, pins[0].pin_comp}, 32'h1);
        xfer(1'b1, `DTG_OFF_TOP, 32'hFF);
        xfer(1'b1, `DTG_OFF_CMP_A, 32'hFE);
        xfer(1'b1, `DTG_OFF_COUNT, 32'h0);
        xfer(1'b1, `DTG_OFF_CTRL, 32'h60);
        xfer(1'b1, `DTG_OFF_CTRL, 32'h860);
        repeat (3) @(posedge hclk);
        chk({31'h0, pins[0].pin_comp}, 32'h1);
        xfer(1'b1, `DTG_OFF_CTRL, 32'h40);
        repeat (3) @(posedge hclk);
        chk({31'h0, pins[0].pin_comp}, 32'h1);
        xfer(1'b1, `DTG_OFF_CTRL, 32'h840);
        repeat (3) @(posedge hclk);
        chk({31'h0, pins[0].pin_comp}, 32'h0);
        xfer(1'b1, `DTG_OFF_TOP, 32'h5);
        xfer(1'b1, `DTG_OFF_COUNT, 32'h0);
        xfer(1'b1, `DTG_OFF_CMP_A, 32'h2);
        xfer(1'b1, `DTG_OFF_CTRL, 32'h60);
        repeat (10) @(posedge hclk);
        chk({31'h0, pins[0].pin_comp}, 32'h1);
        xfer(1'b1, `DTG_OFF_CTRL, 32'h20);
        repeat (8) @(posedge hclk);
        tg = 0;
        pv = pins[0].pin_comp;
        repeat (60) begin
            @(posedge hclk);
            if (pins[0].pin_comp !== pv) tg++;
            pv = pins[0].pin_comp;
        end
        chk(tg, 10);
        $display("test normal mode done");
        xfer(1'b1, `DTG_OFF_TOP, 32'hFF);
        xfer(1'b1, `DTG_OFF_CMP_A, 32'h7F);
        for (int s = 0; s < 4; s++) begin
            n = $urandom_range(15, 1);
            xfer(1'b1, `DTG_OFF_DEADTIME, {n[3:0], 4'h1});
            xfer(1'b1, `DTG_OFF_CTRL, 32'h21 | (s << 3));
            repeat (700) @(posedge hclk);
            chk_in(gap_last, ((n - 1) << s) + 2, (n << s) + 1);
        end
        chk(shoot_cnt, 0);
        chk_in(rise_cnt, 4, 1000);
        xfer(1'b1, `DTG_OFF_CTRL, 32'h25);
        repeat (530) @(posedge hclk);
        chk_in(shoot_cnt, 1, 1000);
        $display("test dead time done");
        give_verdict;
    end
endmodule
`default_nettype wire
